//--- hdl/pc_unit_pkg.sv
package pc_unit_pkg;
  localparam int PC_WIDTH        = 13;
  localparam int LOW_WIDTH       = 8;
  localparam int UPPER_WIDTH     = 5;
  localparam int TARGET_WIDTH    = 11;
  localparam int PAGE_WIDTH      = 2;
  localparam int STACK_DEPTH     = 8;
  localparam int STACK_PTR_WIDTH = 3;
  localparam int DATA_ADDR_WIDTH = 9;
  localparam int LATCH_UPPER_MSB = 4;
  localparam int LATCH_PAGE_LSB  = 3;
  localparam logic [12:0] PC_RESET_VALUE = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
  localparam logic [7:0]  INDIRECT_LOC   = 8'h00;
  localparam logic [7:0]  INDIRECT_READ_VALUE = 8'h00;
  localparam logic [7:0]  LATCH_RESET_VALUE   = 8'h00;

  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] ADDR_PC_LOW    = 8'h00;
  localparam logic [7:0] ADDR_PC_LATCH  = 8'h04;
  localparam logic [7:0] ADDR_POINTER   = 8'h08;
  localparam logic [7:0] ADDR_CONTROL   = 8'h0C;
  localparam logic [7:0] ADDR_PC_FULL   = 8'h10;
  localparam logic [7:0] ADDR_DATA_ADDR = 8'h14;
  localparam int         CTRL_BANK_BIT  = 0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_STEP,
    OP_CALL,
    OP_JUMP,
    OP_RETURN,
    OP_IRQ,
    OP_INTERRUPT_EXIT_INSTR
  } flow_op_t;
endpackage : pc_unit_pkg

//--- hdl/return_stack.sv
module return_stack
  import pc_unit_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_WIDTH,
  parameter int PTR_W = STACK_PTR_WIDTH
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             push_in,
  input  wire logic             pop_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  output logic      [WIDTH-1:0] top_out
);
  // Pointer is private: no port exposes it
  logic [PTR_W-1:0] ptr;
  logic [WIDTH-1:0] entry [DEPTH];
  logic [PTR_W-1:0] top_idx;

  assign top_idx = ptr - PTR_W'(1);
  assign top_out = entry[top_idx];

  // Wrap in both directions, no overflow flag
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ptr <= '0;
    end else if (push_in) begin
      ptr <= ptr + PTR_W'(1);
    end else if (pop_in) begin
      ptr <= top_idx;
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk_in) begin
        if (push_in && ptr == PTR_W'(i)) begin
          entry[i] <= push_data_in;
        end
      end
    end
  endgenerate
endmodule : return_stack

//--- hdl/indirect_addr.sv
module indirect_addr
  import pc_unit_pkg::*;
(
  input  wire logic [LOW_WIDTH-1:0]       pointer_in,
  input  wire logic                       bank_in,
  input  wire logic [LOW_WIDTH-1:0]       file_addr_in,
  output logic      [DATA_ADDR_WIDTH-1:0] data_addr_out,
  output logic                            self_ref_out
);
  logic use_pointer;

  assign use_pointer   = (file_addr_in == INDIRECT_LOC);
  assign data_addr_out = use_pointer ? {bank_in, pointer_in}
                                     : {bank_in, file_addr_in};
  assign self_ref_out  = use_pointer && (pointer_in == INDIRECT_LOC);
endmodule : indirect_addr

//--- hdl/program_flow_unit.sv
// Overview of operation
// - Program counter is 13 bits; low byte readable and writable as a register.
// - Upper five counter bits are not accessible; they come from the latch. The code reads them back at ADDR_PC_FULL.
// - Writing the low byte loads upper counter bits from latch bits 4..0.
// - Call and jump take 11 bits from instruction, top two from latch 4..3.
// - Every reset clears the program counter to zero.
// - Eight-entry 13-bit return stack outside memory; pointer hidden.
// - Calls and interrupt vectoring push the program counter.
// - Return and interrupt return pop the full counter.
// - Pushes and pops never change the high-byte latch.
// - Stack is circular; the ninth push overwrites the oldest entry.
// - No overflow or underflow status exists; wrap is silent.
// - Counter spans 8K words, split into 2K pages for jumps.
// - Accessing the indirect location accesses the pointed-to data address.
// - Reading the indirect location through the pointer returns zero.
// - Writing the indirect location through the pointer stores nothing.
// - Indirect address is bank bit above the 8-bit pointer: nine bits.
// - Wake-up from sleep continues at the next address, counter kept.
// - Interrupt wake with enable set runs next, pushes, then loads vector.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
module program_flow_unit
  import pc_unit_pkg::*;
(
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  // Decoder side
  input  wire logic [2:0]                  flow_op_in,
  input  wire logic [TARGET_WIDTH-1:0]     target_in,
  input  wire logic                        wake_in,
  input  wire logic                        global_irq_enable_in,
  input  wire logic                        file_wr_in,
  input  wire logic [LOW_WIDTH-1:0]        file_addr_in,
  input  wire logic [LOW_WIDTH-1:0]        file_wdata_in,
  output logic      [PC_WIDTH-1:0]         pc_out,
  output logic      [DATA_ADDR_WIDTH-1:0]  data_addr_out,
  output logic                             data_wr_en_out,
  output logic                             read_zero_out,
  // AXI4-Lite slave
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  logic [PC_WIDTH-1:0]        pc;
  logic [LOW_WIDTH-1:0]       pc_high_latch;
  logic [LOW_WIDTH-1:0]       indirect_pointer_reg;
  logic                       indirect_bank_bit;
  logic                       pending_vector;
  logic [PC_WIDTH-1:0]        next_pc;
  logic [PC_WIDTH-1:0]        pc_plus_one;
  logic [PC_WIDTH-1:0]        stack_top;
  logic [UPPER_WIDTH-1:0]     pc_upper_bits;
  logic [PAGE_WIDTH-1:0]      page_bits;
  logic [DATA_ADDR_WIDTH-1:0] next_data_addr;
  logic                       self_ref;
  flow_op_t                   op;

  assign op            = flow_op_t'(flow_op_in);
  assign pc_plus_one   = pc + PC_WIDTH'(1);
  assign pc_upper_bits = pc_high_latch[LATCH_UPPER_MSB:0];
  assign page_bits     = pc_high_latch[LATCH_UPPER_MSB:LATCH_PAGE_LSB];

  // AXI write path
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;
  logic       wr_low;
  logic       wr_latch;
  logic       wr_pointer;
  logic       wr_control;
  logic       wr_mapped;
  logic       aw_take;
  logic       w_take;

  assign aw_take    = s_axi_awvalid && s_axi_awready;
  assign w_take     = s_axi_wvalid && s_axi_wready;
  assign wr_fire    = aw_held && w_held && !s_axi_bvalid;
  assign wr_low     = wr_fire && aw_addr == ADDR_PC_LOW && w_strb[0];
  assign wr_latch   = wr_fire && aw_addr == ADDR_PC_LATCH && w_strb[0];
  assign wr_pointer = wr_fire && aw_addr == ADDR_POINTER && w_strb[0];
  assign wr_control = wr_fire && aw_addr == ADDR_CONTROL && w_strb[0];
  assign wr_mapped  = aw_addr == ADDR_PC_LOW || aw_addr == ADDR_PC_LATCH
                   || aw_addr == ADDR_POINTER || aw_addr == ADDR_CONTROL;

  // Core file writes to the low counter byte behave like bus writes
  logic core_wr_low;
  assign core_wr_low = file_wr_in && file_addr_in == INDIRECT_LOC + 8'h02;

  logic push;
  logic pop;
  logic pc_load_low;
  logic [LOW_WIDTH-1:0] low_value;

  assign pc_load_low = wr_low || core_wr_low;
  assign low_value   = core_wr_low ? file_wdata_in : w_data[7:0];
  assign push = (op == OP_CALL) || (op == OP_IRQ)
             || (pending_vector && !pc_load_low);
  assign pop  = (op == OP_RETURN) || (op == OP_INTERRUPT_EXIT_INSTR);

  // Counter next-state priority: write of low byte, then pending wake vector, then flow ops
  always_comb begin
    next_pc = pc;
    if (pc_load_low) begin
      next_pc = {pc_upper_bits, low_value};
    end else if (pending_vector) begin
      next_pc = IRQ_VECTOR;
    end else begin
      case (op)
        OP_STEP:   next_pc = pc_plus_one;
        OP_CALL:   next_pc = {page_bits, target_in};
        OP_JUMP:   next_pc = {page_bits, target_in};
        OP_RETURN: next_pc = stack_top;
        OP_INTERRUPT_EXIT_INSTR: next_pc = stack_top;
        OP_IRQ:    next_pc = IRQ_VECTOR;
        OP_NONE:   next_pc = pc;
        default:   next_pc = pc;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pc <= PC_RESET_VALUE;
    end else begin
      pc <= next_pc;
    end
  end

  // Wake keeps the counter; with interrupts enabled the vector waits
  // until the next instruction has run, so that one is not lost
  typedef enum logic [1:0] {
    WAKE_IDLE,
    WAKE_ARMED,
    WAKE_VECTOR
  } wake_state_t;

  wake_state_t wake_state;
  wake_state_t next_wake_state;
  logic        wake_arm;
  logic        wake_step;

  assign wake_arm  = wake_in && global_irq_enable_in;
  assign wake_step = op == OP_STEP && !pc_load_low;

  // A low-byte write while armed drops the pending vector unless a wake with interrupts enabled arrives in the same cycle
  always_comb begin
    next_wake_state = wake_state;
    case (wake_state)
      WAKE_IDLE: begin
        if (wake_arm) begin
          next_wake_state = WAKE_ARMED;
        end
      end
      WAKE_ARMED: begin
        if (wake_step) begin
          next_wake_state = WAKE_VECTOR;
        end else if (pc_load_low && !wake_arm) begin
          next_wake_state = WAKE_IDLE;
        end
      end
      WAKE_VECTOR: begin
        next_wake_state = wake_arm ? WAKE_ARMED : WAKE_IDLE;
      end
      default: begin
        next_wake_state = WAKE_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wake_state <= WAKE_IDLE;
    end else begin
      wake_state <= next_wake_state;
    end
  end

  assign pending_vector = wake_state == WAKE_VECTOR;

  // Latch only changes by explicit write; stack traffic leaves it alone
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pc_high_latch <= LATCH_RESET_VALUE;
    end else if (wr_latch) begin
      pc_high_latch <= w_data[7:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      indirect_pointer_reg <= '0;
      indirect_bank_bit    <= 1'b0;
    end else begin
      if (wr_pointer) begin
        indirect_pointer_reg <= w_data[7:0];
      end
      if (wr_control) begin
        indirect_bank_bit <= w_data[CTRL_BANK_BIT];
      end
    end
  end

  return_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_WIDTH),
    .PTR_W (STACK_PTR_WIDTH)
  ) u_stack (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .push_in      (push),
    .pop_in       (pop),
    .push_data_in (pending_vector ? pc : pc_plus_one),
    .top_out      (stack_top)
  );

  indirect_addr u_indirect (
    .pointer_in    (indirect_pointer_reg),
    .bank_in       (indirect_bank_bit),
    .file_addr_in  (file_addr_in),
    .data_addr_out (next_data_addr),
    .self_ref_out  (self_ref)
  );

  // Decoder-facing outputs registered one cycle behind their inputs
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pc_out         <= PC_RESET_VALUE;
      data_addr_out  <= '0;
      data_wr_en_out <= 1'b0;
      read_zero_out  <= 1'b0;
    end else begin
      pc_out         <= next_pc;
      data_addr_out  <= next_data_addr;
      data_wr_en_out <= file_wr_in && !self_ref && !core_wr_low;
      read_zero_out  <= self_ref;
    end
  end

  // Ready pulses for one cycle; the two channels may arrive in either order
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path: one-cycle address accept, data next cycle
  logic [31:0] rd_value;
  logic        rd_mapped;
  logic        rd_take;

  assign rd_take   = s_axi_arvalid && s_axi_arready;
  assign rd_mapped = s_axi_araddr == ADDR_PC_LOW || s_axi_araddr == ADDR_PC_LATCH
                  || s_axi_araddr == ADDR_POINTER || s_axi_araddr == ADDR_CONTROL
                  || s_axi_araddr == ADDR_PC_FULL || s_axi_araddr == ADDR_DATA_ADDR;
  assign rd_value =
      (s_axi_araddr == ADDR_PC_LOW)    ? {24'h000000, pc[7:0]} :
      (s_axi_araddr == ADDR_PC_LATCH)  ? {24'h000000, pc_high_latch} :
      (s_axi_araddr == ADDR_POINTER)   ? {24'h000000, indirect_pointer_reg} :
      (s_axi_araddr == ADDR_CONTROL)   ? {31'h00000000, indirect_bank_bit} :
      (s_axi_araddr == ADDR_PC_FULL)   ? {19'h00000, pc} :
      (s_axi_araddr == ADDR_DATA_ADDR) ? {23'h000000, indirect_bank_bit,
                                          indirect_pointer_reg} :
      32'h00000000;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  // Response stands until the master takes it
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid <= 1'b0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end
endmodule : program_flow_unit

//--- bench/program_flow_unit_assertions.sv
module program_flow_unit_assertions
  import pc_unit_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic [2:0]  flow_op_in,
  input wire logic [10:0] target_in,
  input wire logic        wake_in,
  input wire logic        global_irq_enable_in,
  input wire logic        file_wr_in,
  input wire logic [7:0]  file_addr_in,
  input wire logic [7:0]  file_wdata_in,
  input wire logic [12:0] pc_out,
  input wire logic [8:0]  data_addr_out,
  input wire logic        data_wr_en_out,
  input wire logic        read_zero_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_step_adds_one: assert property (flow_op_in == OP_STEP && !file_wr_in
    |=> pc_out == $past(pc_out) + 13'h1) else $error("step did not add one");
  a_call_target: assert property (flow_op_in == OP_CALL && !file_wr_in
    |=> pc_out[10:0] == $past(target_in)) else $error("call target wrong");
  a_jump_target: assert property (flow_op_in == OP_JUMP && !file_wr_in
    |=> pc_out[10:0] == $past(target_in)) else $error("jump target wrong");
  a_call_then_return: assert property (flow_op_in == OP_CALL && !file_wr_in ##1
    flow_op_in == OP_RETURN && !file_wr_in |=> pc_out == $past(pc_out, 2) + 13'h1)
    else $error("return address wrong");
  a_irq_vector: assert property (flow_op_in == OP_IRQ && !file_wr_in
    |=> pc_out == IRQ_VECTOR) else $error("vector not loaded");
  a_wake_vector: assert property (wake_in && global_irq_enable_in ##1
    flow_op_in == OP_STEP && !file_wr_in |=> ##1 pc_out == IRQ_VECTOR)
    else $error("wake did not vector");
  a_reset_clears: assert property (disable iff (1'b0) !rst_n_in
    |=> pc_out == PC_RESET_VALUE) else $error("reset did not clear counter");
  a_low_write: assert property (file_wr_in && file_addr_in == 8'h02
    |=> pc_out[7:0] == $past(file_wdata_in)) else $error("low byte write lost");
  a_direct_addr: assert property (file_addr_in != INDIRECT_LOC
    |=> data_addr_out[7:0] == $past(file_addr_in)) else $error("direct address wrong");
  a_self_ref_blocked: assert property (read_zero_out
    |-> !data_wr_en_out && data_addr_out[7:0] == INDIRECT_LOC) else $error("self reference");

  c_call: cover property (flow_op_in == OP_CALL);
  c_wake: cover property (wake_in && global_irq_enable_in);
  c_self_ref: cover property (read_zero_out);
endmodule : program_flow_unit_assertions

bind program_flow_unit program_flow_unit_assertions u_chk (.mclk_in, .rst_n_in, .flow_op_in,
  .target_in, .wake_in, .global_irq_enable_in, .file_wr_in, .file_addr_in, .file_wdata_in,
  .pc_out, .data_addr_out, .data_wr_en_out, .read_zero_out);

//--- bench/decoder_model.sv
module decoder_model
  import pc_unit_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic [2:0]  cmd_op_in,
  input  wire logic [10:0] cmd_target_in,
  input  wire logic        cmd_wake_in,
  output logic      [2:0]  flow_op_out,
  output logic      [10:0] target_out,
  output logic             wake_out
);
  // One instruction per cycle; wake follows its command input, one cycle late
  always_ff @(posedge mclk_in) begin
    flow_op_out <= rst_n_in ? cmd_op_in : OP_NONE;
    target_out  <= cmd_target_in;
    wake_out    <= rst_n_in & cmd_wake_in;
  end
endmodule : decoder_model

//--- bench/program_flow_unit_tb.sv
module program_flow_unit_tb
  import pc_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, global_irq_enable, fwr, cwake, wake, awv, wv, br, arv, rr;
  logic        awr, wr, bv, arr, rv, wen, rzero;
  logic [1:0]  bresp, rresp;
  logic [3:0]  strb;
  logic [2:0]  cop, fop;
  logic [7:0]  faddr, fdata, awaddr, araddr;
  logic [8:0]  daddr;
  logic [10:0] ctgt, tgt;
  logic [12:0] pc, pc_exp;
  logic [12:0] stk [8];
  logic [31:0] wdata, rdata;
  int          bad_count, checks, sp, i;

  program_flow_unit u_dut (.mclk_in(clk), .rst_n_in(rst_n), .flow_op_in(fop), .target_in(tgt),
    .wake_in(wake), .global_irq_enable_in(global_irq_enable), .file_wr_in(fwr), .file_addr_in(faddr),
    .file_wdata_in(fdata), .pc_out(pc), .data_addr_out(daddr), .data_wr_en_out(wen),
    .read_zero_out(rzero), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  decoder_model u_dec (.mclk_in(clk), .rst_n_in(rst_n), .cmd_op_in(cop), .cmd_target_in(ctgt),
    .cmd_wake_in(cwake), .flow_op_out(fop), .target_out(tgt), .wake_out(wake));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task finish_test();
    $display("mismatches %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task limit(input int n);
    if (n >= 40) begin
      bad_count++;
      finish_test();
    end
  endtask : limit

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    {awaddr, wdata} <= {a, d};
    {awv, wv, br} <= 3'h7;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    limit(n);
    chk(bresp, er);
  endtask : axw

  task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    {arv, rr} <= 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    limit(n);
    chk(rdata, e);
    chk(rresp, er);
  endtask : axr

  task issue(input logic [2:0] op, input logic [10:0] t, input logic w);
    @(posedge clk);
    {cop, ctgt, cwake} <= {op, t, w};
  endtask : issue

  task run(input logic [2:0] op, input logic [10:0] t);
    issue(op, t, 1'b0);
    issue(OP_NONE, 11'h000, 1'b0);
    @(posedge clk);
    #1;
  endtask : run

  task fa(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {fwr, faddr, fdata} <= {w, a, d};
    @(posedge clk);
    fwr <= 1'b0;
    #1;
  endtask : fa

  // Mirror of the return stack; wraps the same way the hardware must
  task call(input logic [10:0] t);
    stk[sp] = pc_exp + 13'h1;
    sp = (sp + 1) % 8;
    pc_exp = {2'b01, t};
    run(OP_CALL, t);
    chk(pc, pc_exp);
  endtask : call

  task ret();
    sp = (sp + 7) % 8;
    pc_exp = stk[sp];
    run(OP_RETURN, 11'h000);
    chk(pc, pc_exp);
  endtask : ret

  initial begin
    #1000000;
    bad_count++;
    finish_test();
  end

  initial begin
    {rst_n, awv, wv, br, arv, rr, fwr, global_irq_enable, cwake} = '0;
    {cop, ctgt, faddr, fdata, awaddr, araddr, wdata} = '0;
    {bad_count, checks, sp} = '0;
    strb = 4'hF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(pc, PC_RESET_VALUE);
    axr(ADDR_PC_FULL, 32'h0, RESP_OKAY);
    axw(ADDR_PC_LATCH, 32'h1F, RESP_OKAY);
    axw(ADDR_PC_LOW, 32'h34, RESP_OKAY);
    #1 chk(pc, 13'h1F34);
    axr(ADDR_PC_LOW, 32'h34, RESP_OKAY);
    axr(ADDR_PC_FULL, 32'h1F34, RESP_OKAY);
    run(OP_STEP, 11'h000);
    chk(pc, 13'h1F35);
    fa(1'b1, 8'h02, 8'h77);
    chk(pc, 13'h1F77);
    run(OP_JUMP, 11'h123);
    chk(pc, 13'h1923);
    axw(ADDR_PC_LATCH, 32'h08, RESP_OKAY);
    pc_exp = 13'h1923;
    for (i = 0; i < 9; i++) call(11'h003 + 11'(i * 16));
    for (i = 0; i < 9; i++) ret();
    axr(ADDR_PC_LATCH, 32'h08, RESP_OKAY);
    strb <= 4'h0;
    axw(ADDR_PC_LATCH, 32'h1F, RESP_OKAY);
    strb <= 4'hF;
    axr(ADDR_PC_LATCH, 32'h08, RESP_OKAY);
    issue(OP_CALL, 11'h055, 1'b0);
    issue(OP_RETURN, 11'h000, 1'b0);
    issue(OP_NONE, 11'h000, 1'b0);
    @(posedge clk);
    #1 chk(pc, pc_exp + 13'h1);
    run(OP_IRQ, 11'h000);
    chk(pc, IRQ_VECTOR);
    run(OP_INTERRUPT_EXIT_INSTR, 11'h000);
    chk(pc, pc_exp + 13'h2);
    fa(1'b1, 8'h02, 8'h10);
    pc_exp = 13'h0810;
    chk(pc, pc_exp);
    // Wake with interrupts disabled just resumes
    issue(OP_NONE, 11'h000, 1'b1);
    issue(OP_STEP, 11'h000, 1'b0);
    issue(OP_NONE, 11'h000, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk(pc, pc_exp + 13'h1);
    pc_exp = pc_exp + 13'h1;
    @(posedge clk) global_irq_enable <= 1'b1;
    issue(OP_NONE, 11'h000, 1'b1);
    issue(OP_STEP, 11'h000, 1'b0);
    issue(OP_NONE, 11'h000, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk(pc, IRQ_VECTOR);
    run(OP_INTERRUPT_EXIT_INSTR, 11'h000);
    chk(pc, pc_exp + 13'h1);
    axw(ADDR_POINTER, 32'h45, RESP_OKAY);
    axw(ADDR_CONTROL, 32'h1, RESP_OKAY);
    fa(1'b1, 8'h00, 8'h55);
    chk(daddr, 9'h145);
    chk({wen, rzero}, 2'b10);
    fa(1'b1, 8'h20, 8'h55);
    chk(daddr, 9'h120);
    axr(ADDR_DATA_ADDR, 32'h145, RESP_OKAY);
    axw(ADDR_POINTER, 32'h0, RESP_OKAY);
    fa(1'b1, 8'h00, 8'hAA);
    chk(daddr, 9'h100);
    chk({wen, rzero}, 2'b01);
    axr(8'h18, 32'h0, RESP_SLVERR);
    axw(8'h1C, 32'hFF, RESP_SLVERR);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(pc, PC_RESET_VALUE);
    axr(ADDR_PC_LATCH, 32'h0, RESP_OKAY);
    finish_test();
  end
endmodule : program_flow_unit_tb
